/* spcr_core.sv */
// Pulse generators, multipurpose pin setup and host scratch byte
`timescale 1ns/100ps
`include "spcr_defs.svh"
// Contract
// - Fail duty field picks 20/10/5/2.5 percent
// - Pin two: fail three, off, wake, LS, HS
// - Pin one: fail two, off, wake, LS, HS
// - Channel one duty: 0 off, FF on, n/255
// - Channel two duty behaves the same
// - Frequency bits 0 and 2: 200/400 Hz
// - Frequency reserved bits read zero, ignore writes
// - Duty cleared on power-on, soft; kept restart
// - Frequency cleared power-on, soft; kept restart
// - Scratch byte host only, never used internally
// - Scratch byte cleared only by power-on
// - Scratch access only in normal mode
// - Switch code 100 channel one, 101 two
// - Frame: 7-bit address, access bit, data
module spcr_core #(
    parameter int HS_NUM = 4,
    parameter int FO_STEP_CYC = `SPCR_FO_STEP_CYC,
    parameter int WAKE_FILT_CYC = `SPCR_WAKE_FILT_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic spi_sck,
    input wire logic spi_csn,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire logic soft_reset,
    input wire logic restart_mode,
    input wire logic normal_mode,
    input wire logic fail_active,
    input wire logic [1:0] pin_wake_in,
    input wire logic [HS_NUM*3-1:0] hs_cfg,
    output logic pulse_one_out,
    output logic pulse_two_out,
    output logic [HS_NUM-1:0] hs_pwm_drive,
    output logic [HS_NUM-1:0] hs_pwm_ctl,
    output logic [1:0] pin_fail_drive,
    output logic [1:0] pin_low_side_on,
    output logic [1:0] pin_high_side_on,
    output logic [1:0] pin_wake_en,
    output logic [1:0] pin_wake_level
);
    import spcr_pkg::*;
    localparam int FW = $clog2(FO_STEP_CYC + 1);
    localparam int WW = $clog2(WAKE_FILT_CYC + 1);
    localparam logic [FW-1:0] FO_LIM = FW'(FO_STEP_CYC - 1);
    localparam logic [WW-1:0] WAKE_LIM = WW'(WAKE_FILT_CYC - 1);

    spcr_frame_if frm ();
    spcr_pwm_if pw1 ();
    spcr_pwm_if pw2 ();

    logic [7:0] duty1_r;
    logic [7:0] duty2_r;
    logic freq1_r;
    logic freq2_r;
    logic [7:0] scratch_r;
    logic [7:0] multipin_r;
    logic [FW-1:0] fo_div_r;
    logic [5:0] fo_slot_r;
    logic fo_pulse_r;
    logic [HS_NUM-1:0] hs_drive_r;
    logic [HS_NUM-1:0] hs_ctl_r;

    // Frame port
    spcr_spi_frame u_frame (
        .clk(clk),
        .nrst(nrst),
        .spi_sck(spi_sck),
        .spi_csn(spi_csn),
        .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe),
        .frm(frm.spi)
    );

    // Write strobes, committed at the end of a complete frame
    wire [7:0] wdata = frm.wdata;
    wire wr_hit = frm.done & frm.wr;
    wire wr_pwm1 = wr_hit & (frm.addr == `SPCR_ADDR_PWM1);
    wire wr_pwm2 = wr_hit & (frm.addr == `SPCR_ADDR_PWM2);
    wire wr_freq = wr_hit & (frm.addr == `SPCR_ADDR_FREQ);
    wire wr_pin = wr_hit & (frm.addr == `SPCR_ADDR_MULTIPIN);
    // Scratch writes outside normal mode are dropped
    wire wr_scr = wr_hit & (frm.addr == `SPCR_ADDR_SCRATCH)
        & normal_mode;

    // Read back, reserved frequency bits forced to zero
    wire [7:0] freq_rd = {5'h00, freq2_r, 1'b0, freq1_r};
    wire [7:0] scr_rd = normal_mode ? scratch_r : 8'h00;
    assign frm.rdata =
        (frm.addr == `SPCR_ADDR_PWM1) ? duty1_r :
        (frm.addr == `SPCR_ADDR_PWM2) ? duty2_r :
        (frm.addr == `SPCR_ADDR_FREQ) ? freq_rd :
        (frm.addr == `SPCR_ADDR_SCRATCH) ? scr_rd :
        (frm.addr == `SPCR_ADDR_MULTIPIN) ? multipin_r :
        8'h00;

    // Control registers; restart mode has no clearing effect here
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            duty1_r <= `SPCR_RST_DUTY;
            duty2_r <= `SPCR_RST_DUTY;
            freq1_r <= `SPCR_RST_FREQ;
            freq2_r <= `SPCR_RST_FREQ;
            multipin_r <= `SPCR_RST_MULTIPIN;
        end else if (soft_reset) begin
            duty1_r <= `SPCR_RST_DUTY;
            duty2_r <= `SPCR_RST_DUTY;
            freq1_r <= `SPCR_RST_FREQ;
            freq2_r <= `SPCR_RST_FREQ;
            multipin_r <= `SPCR_RST_MULTIPIN;
        end else begin
            if (wr_pwm1) begin
                duty1_r <= wdata;
            end
            if (wr_pwm2) begin
                duty2_r <= wdata;
            end
            if (wr_freq) begin
                freq1_r <= wdata[`SPCR_FREQ1_BIT];
                freq2_r <= wdata[`SPCR_FREQ2_BIT];
            end
            if (wr_pin) begin
                multipin_r <= wdata;
            end
        end
    end

    // Scratch byte survives soft reset, only power-on clears it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scratch_r <= `SPCR_RST_SCRATCH;
        end else if (wr_scr) begin
            scratch_r <= wdata;
        end
    end

    // Two pulse channels
    assign pw1.duty = duty1_r;
    assign pw1.freq_sel = freq1_r;
    assign pw2.duty = duty2_r;
    assign pw2.freq_sel = freq2_r;
    spcr_pwm_chan u_pwm_one (
        .clk(clk),
        .nrst(nrst),
        .pw(pw1.chan)
    );
    spcr_pwm_chan u_pwm_two (
        .clk(clk),
        .nrst(nrst),
        .pw(pw2.chan)
    );
    assign pulse_one_out = pw1.level;
    assign pulse_two_out = pw2.level;

    // Fail duty: period of 40 slots, 1/2/4/8 of them on
    wire [1:0] fo_duty = multipin_r[`SPCR_FAIL_OUT_DUTY_SEL_MSB:`SPCR_FAIL_OUT_DUTY_SEL_LSB];
    wire [5:0] fo_on_slots =
        (fo_duty == FO_DUTY_20) ? 6'h08 :
        (fo_duty == FO_DUTY_10) ? 6'h04 :
        (fo_duty == FO_DUTY_5) ? 6'h02 :
        6'h01;
    wire fo_tick = (fo_div_r >= FO_LIM);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fo_div_r <= '0;
            fo_slot_r <= 6'h00;
            fo_pulse_r <= 1'b0;
        end else begin
            fo_div_r <= fo_tick ? '0 : fo_div_r + FW'(1);
            if (fo_tick) begin
                fo_slot_r <= (fo_slot_r >= `SPCR_FO_SLOTS - 6'h01) ?
                    6'h00 : fo_slot_r + 6'h01;
            end
            fo_pulse_r <= (fo_slot_r < fo_on_slots);
        end
    end

    // Pin decode and wake filters; index 0 is pin one, 1 is pin two
    wire [2:0] pin_cfg [2];
    assign pin_cfg[0] = multipin_r[`SPCR_PIN1_MSB:`SPCR_PIN1_LSB];
    assign pin_cfg[1] = multipin_r[`SPCR_PIN2_MSB:`SPCR_PIN2_LSB];
    // Pin one carries the static fail level, pin two the pulsed one
    wire [1:0] fail_src = {fail_active & fo_pulse_r, fail_active};

    for (genvar p = 0; p < 2; p++) begin : g_pin
        logic [1:0] wk_s_r;
        logic [WW-1:0] wk_cnt_r;
        logic wk_lvl_r;
        logic fail_r;
        logic ls_r;
        logic hs_r;
        logic wen_r;
        wire fail_sel = ~pin_cfg[p][2];
        wire is_wake = (pin_cfg[p] == PIN_WAKE);
        wire wk_diff = wk_s_r[1] ^ wk_lvl_r;

        // Static filter: level must stand the full time to pass
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                wk_s_r <= 2'h0;
                wk_cnt_r <= '0;
                wk_lvl_r <= 1'b0;
            end else begin
                wk_s_r <= {wk_s_r[0], pin_wake_in[p]};
                if (!is_wake || !wk_diff) begin
                    wk_cnt_r <= '0;
                end else if (wk_cnt_r >= WAKE_LIM) begin
                    wk_cnt_r <= '0;
                    wk_lvl_r <= wk_s_r[1];
                end else begin
                    wk_cnt_r <= wk_cnt_r + WW'(1);
                end
            end
        end

        // Registered pin drives
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                fail_r <= 1'b0;
                ls_r <= 1'b0;
                hs_r <= 1'b0;
                wen_r <= 1'b0;
            end else begin
                fail_r <= fail_sel & fail_src[p];
                ls_r <= (pin_cfg[p] == PIN_LOW_SIDE);
                hs_r <= (pin_cfg[p] == PIN_HIGH_SIDE);
                wen_r <= is_wake;
            end
        end
        assign pin_fail_drive[p] = fail_r;
        assign pin_low_side_on[p] = ls_r;
        assign pin_high_side_on[p] = hs_r;
        assign pin_wake_en[p] = wen_r;
        assign pin_wake_level[p] = wk_lvl_r & wen_r;
    end

    // Route channels to high-side switches by their config code
    for (genvar h = 0; h < HS_NUM; h++) begin : g_hs
        wire [2:0] code = hs_cfg[h*3 +: 3];
        wire by_one = (code == HS_BY_PULSE_ONE);
        wire by_two = (code == HS_BY_PULSE_TWO);
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                hs_drive_r[h] <= 1'b0;
                hs_ctl_r[h] <= 1'b0;
            end else begin
                hs_drive_r[h] <= (by_one & pw1.level) |
                    (by_two & pw2.level);
                hs_ctl_r[h] <= by_one | by_two;
            end
        end
    end
    assign hs_pwm_drive = hs_drive_r;
    assign hs_pwm_ctl = hs_ctl_r;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    AST_FO_SLOTS: assert property (
        fo_slot_r >= 6'h08 |=> !fo_pulse_r)
        else $error("fail pulse on past its slots");
    AST_PIN2_OFF: assert property (
        pin_cfg[1] == PIN_OFF [*2] |-> !pin_low_side_on[1] &&
        !pin_high_side_on[1] && !pin_fail_drive[1] && !pin_wake_en[1])
        else $error("pin two driven while off");
    AST_PIN1_LS: assert property (
        pin_cfg[0] == PIN_LOW_SIDE |=> pin_low_side_on[0] &&
        !pin_high_side_on[0])
        else $error("pin one low-side not on");
    AST_PWM1_OFF: assert property (
        duty1_r == `SPCR_DUTY_OFF [*2] |-> !pulse_one_out)
        else $error("channel one on at zero duty");
    AST_PWM1_ON: assert property (
        duty1_r == `SPCR_DUTY_FULL [*2] |-> pulse_one_out)
        else $error("channel one off at full duty");
    AST_PWM2_OFF: assert property (
        duty2_r == `SPCR_DUTY_OFF [*2] |-> !pulse_two_out)
        else $error("channel two on at zero duty");
    AST_FREQ_RSVD: assert property (
        wr_freq && !soft_reset |=> freq_rd ==
        {5'h00, $past(wdata[2]), 1'b0, $past(wdata[0])})
        else $error("frequency readback wrong");
    AST_SOFT_CLR: assert property (
        soft_reset |=> duty1_r == `SPCR_DUTY_OFF &&
        duty2_r == `SPCR_DUTY_OFF && freq_rd == 8'h00)
        else $error("soft reset left settings");
    AST_RESTART_KEEP: assert property (
        restart_mode && !soft_reset && !wr_freq && !wr_pwm1
        |=> $stable(freq_rd) && $stable(duty1_r))
        else $error("restart changed settings");
    AST_SCR_SOFT: assert property (
        soft_reset && !wr_scr |=> scratch_r == $past(scratch_r))
        else $error("soft reset touched scratch");
    AST_SCR_GATE: assert property (
        wr_hit && frm.addr == `SPCR_ADDR_SCRATCH && !normal_mode
        |=> $stable(scratch_r))
        else $error("scratch written outside normal mode");
    AST_HS_ROUTE: assert property (
        hs_cfg[2:0] == HS_BY_PULSE_ONE |=>
        hs_pwm_drive[0] == $past(pw1.level) && hs_pwm_ctl[0])
        else $error("switch zero not following channel one");

    COV_PWM1_WR: cover property (wr_pwm1 ##1 duty1_r != 8'h00);
    COV_SCR_WR: cover property (wr_scr);
    COV_PIN2_WAKE: cover property (pin_wake_level[1]);
    COV_FO_PULSE: cover property (pin_fail_drive[1]);
endmodule

/* spcr_defs.svh */
// Register map, field positions, reset values and timing counts
`ifndef SPCR_DEFS_SVH
`define SPCR_DEFS_SVH

// Register addresses, 7 bits as carried in the frame
`define SPCR_ADDR_MULTIPIN 7'h17
`define SPCR_ADDR_PWM1 7'h18
`define SPCR_ADDR_PWM2 7'h19
`define SPCR_ADDR_FREQ 7'h1C
`define SPCR_ADDR_SCRATCH 7'h1E

// Reset values
`define SPCR_RST_DUTY 8'h00
`define SPCR_RST_FREQ 1'h0
`define SPCR_RST_SCRATCH 8'h00
`define SPCR_RST_MULTIPIN 8'h00

// Field positions
`define SPCR_FREQ1_BIT 0
`define SPCR_FREQ2_BIT 2
`define SPCR_FAIL_OUT_DUTY_SEL_MSB 7
`define SPCR_FAIL_OUT_DUTY_SEL_LSB 6
`define SPCR_PIN2_MSB 5
`define SPCR_PIN2_LSB 3
`define SPCR_PIN1_MSB 2
`define SPCR_PIN1_LSB 0

// Frame layout
`define SPCR_FRAME_BITS 5'h10
`define SPCR_HDR_BITS 5'h08
`define SPCR_LOAD_BIT 5'h07

// Timing
`define SPCR_CLK_NS 20
`define SPCR_PWM_STEPS 255
`define SPCR_PWM200_NS 5000000
`define SPCR_PWM400_NS 2500000
`define SPCR_PWM200_STEP (`SPCR_PWM200_NS / `SPCR_CLK_NS / `SPCR_PWM_STEPS)
`define SPCR_PWM400_STEP (`SPCR_PWM400_NS / `SPCR_CLK_NS / `SPCR_PWM_STEPS)
`define SPCR_WAKE_FILT_NS 16000
`define SPCR_WAKE_FILT_CYC \
    ((`SPCR_WAKE_FILT_NS + `SPCR_CLK_NS - 1) / `SPCR_CLK_NS)
`define SPCR_FO_SLOTS 6'h28
`define SPCR_FO_STEP_CYC 1250000

// Duty codes
`define SPCR_DUTY_OFF 8'h00
`define SPCR_DUTY_FULL 8'hFF

`endif

/* spcr_pkg.sv */
// Types shared by the pulse and pin configuration block
package spcr_pkg;
    typedef enum logic [2:0] {
        PIN_OFF = 3'b100,
        PIN_WAKE = 3'b101,
        PIN_LOW_SIDE = 3'b110,
        PIN_HIGH_SIDE = 3'b111
    } spcr_pin_mode_type;
    typedef enum logic [1:0] {
        FO_DUTY_20 = 2'b00,
        FO_DUTY_10 = 2'b01,
        FO_DUTY_5 = 2'b10,
        FO_DUTY_2P5 = 2'b11
    } spcr_fo_duty_type;
    typedef enum logic [2:0] {
        HS_BY_PULSE_ONE = 3'b100,
        HS_BY_PULSE_TWO = 3'b101
    } spcr_hs_route_type;
endpackage

/* spcr_if.sv */
// Carriers between the register core, the frame port and the channels
`timescale 1ns/100ps
interface spcr_pwm_if;
    logic [7:0] duty;
    logic freq_sel;
    logic level;
    modport ctl(output duty, output freq_sel, input level);
    modport chan(input duty, input freq_sel, output level);
endinterface

interface spcr_frame_if;
    logic done;
    logic [6:0] addr;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctl(input done, input addr, input wr, input wdata,
        output rdata);
    modport spi(output done, output addr, output wr, output wdata,
        input rdata);
endinterface

/* spcr_pwm_chan.sv */
// One pulse-width channel: 255 steps per period, 200 or 400 Hz
`timescale 1ns/100ps
`include "spcr_defs.svh"
module spcr_pwm_chan #(
    parameter int STEP_SLOW = `SPCR_PWM200_STEP,
    parameter int STEP_FAST = `SPCR_PWM400_STEP
) (
    input wire logic clk,
    input wire logic nrst,
    spcr_pwm_if.chan pw
);
    import spcr_pkg::*;
    localparam int DW = $clog2(STEP_SLOW + 1);
    localparam logic [DW-1:0] LIM_SLOW = DW'(STEP_SLOW - 1);
    localparam logic [DW-1:0] LIM_FAST = DW'(STEP_FAST - 1);
    localparam logic [7:0] LAST_STEP = 8'(`SPCR_PWM_STEPS - 1);
    logic [DW-1:0] div_r;
    logic [7:0] step_r;
    logic level_r;
    wire [DW-1:0] div_lim = pw.freq_sel ? LIM_FAST : LIM_SLOW;
    // >= so a switch to the faster rate cannot overrun the divider
    wire step_tick = (div_r >= div_lim);
    wire level_nxt = (pw.duty == `SPCR_DUTY_FULL) ? 1'b1 :
        (step_r < pw.duty);

    // Step divider and step counter, one period is 255 steps
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= '0;
            step_r <= 8'h00;
            level_r <= 1'b0;
        end else begin
            div_r <= step_tick ? '0 : div_r + DW'(1);
            if (step_tick) begin
                step_r <= (step_r >= LAST_STEP) ? 8'h00 : step_r + 8'h01;
            end
            level_r <= level_nxt;
        end
    end
    assign pw.level = level_r;
endmodule

/* spcr_spi_frame.sv */
// 16-bit serial frame port: address, access bit, data byte, LSB first
`timescale 1ns/100ps
`include "spcr_defs.svh"
module spcr_spi_frame (
    input wire logic clk,
    input wire logic nrst,
    input wire logic spi_sck,
    input wire logic spi_csn,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    spcr_frame_if.spi frm
);
    import spcr_pkg::*;
    logic [2:0] sck_s_r;
    logic [2:0] csn_s_r;
    logic [1:0] sdi_s_r;
    logic [15:0] shift_r;
    logic [4:0] cnt_r;
    logic [1:0] load_r;
    logic [6:0] addr_r;
    logic wr_r;
    logic [7:0] tx_r;
    logic sdo_r;
    logic done_r;
    logic [7:0] wdata_r;

    // Pin synchronisers, stage [0] feeds only stage [1]
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sck_s_r <= 3'h0;
            csn_s_r <= 3'h7;
            sdi_s_r <= 2'h0;
        end else begin
            sck_s_r <= {sck_s_r[1:0], spi_sck};
            csn_s_r <= {csn_s_r[1:0], spi_csn};
            sdi_s_r <= {sdi_s_r[0], spi_sdi};
        end
    end
    wire sel = ~csn_s_r[1];
    wire sck_rise = sck_s_r[1] & ~sck_s_r[2];
    wire sck_fall = ~sck_s_r[1] & sck_s_r[2];
    wire cs_end = csn_s_r[1] & ~csn_s_r[2];

    // Shift in on rising clock, out on falling clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shift_r <= 16'h0000;
            cnt_r <= 5'h00;
            load_r <= 2'h0;
            addr_r <= 7'h00;
            wr_r <= 1'b0;
            tx_r <= 8'h00;
            sdo_r <= 1'b0;
            done_r <= 1'b0;
            wdata_r <= 8'h00;
        end else begin
            done_r <= 1'b0;
            load_r <= {load_r[0], 1'b0};
            if (!sel) begin
                cnt_r <= 5'h00;
            end else if (sck_rise) begin
                shift_r <= {sdi_s_r[1], shift_r[15:1]};
                // A 17th bit spoils the frame
                if (cnt_r <= `SPCR_FRAME_BITS) begin
                    cnt_r <= cnt_r + 5'h01;
                end
                load_r[0] <= (cnt_r == `SPCR_LOAD_BIT);
            end
            if (load_r[0]) begin
                addr_r <= shift_r[14:8];
                wr_r <= shift_r[15];
            end
            if (load_r[1]) begin
                tx_r <= frm.rdata;
            end
            if (sck_fall) begin
                if (cnt_r >= `SPCR_HDR_BITS) begin
                    sdo_r <= tx_r[0];
                    tx_r <= {1'b0, tx_r[7:1]};
                end else begin
                    sdo_r <= 1'b0;
                end
            end
            // Only a frame of exactly 16 bits is committed
            if (cs_end && cnt_r == `SPCR_FRAME_BITS) begin
                done_r <= 1'b1;
                wdata_r <= shift_r[15:8];
            end
        end
    end
    assign frm.done = done_r;
    assign frm.addr = addr_r;
    assign frm.wr = wr_r;
    assign frm.wdata = wdata_r;
    assign spi_sdo = sdo_r;
    assign spi_sdo_oe = sel;
endmodule

/* spcr_host_model.sv */
// Host microcontroller side of the serial register frame
`timescale 1ns/100ps
module spcr_host_model (
    input wire logic clk,
    output logic spi_sck,
    output logic spi_csn,
    output logic spi_sdi,
    input wire logic spi_sdo,
    input wire logic spi_sdo_oe
);
    localparam int HALF = 5; // Phases kept above the 4 clk minimum

    // Clock idles low, chip select high outside frames
    initial begin
        spi_sck = 1'h0;
        spi_csn = 1'h1;
        spi_sdi = 1'h0;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One 16-bit frame, LSB first; read byte returns in the same frame
    task automatic xfer(input logic [6:0] addr, input logic wr,
            input logic [7:0] wdata, output logic [7:0] rdata);
        logic [15:0] word;
        word = {wdata, wr, addr};
        rdata = 8'h00;
        cyc(1);
        spi_csn = 1'h0;
        for (int i = 0; i < 16; i++) begin
            spi_sdi = word[i];
            cyc(HALF);
            spi_sck = 1'h1;
            // An undriven output reads as unknown, so it cannot match
            if (i >= 8) rdata[i-8] = spi_sdo_oe ? spi_sdo : 1'hx;
            cyc(HALF);
            spi_sck = 1'h0;
        end
        cyc(HALF);
        spi_csn = 1'h1;
        spi_sdi = ~spi_sdi; // Released line must not look stable
        cyc(8); // Gap above 4 clk, lets the write land
    endtask
endmodule

/* spcr_core_tb.sv */
// Self-checking bench for the pulse and pin configuration block
`timescale 1ns/100ps
`include "spcr_defs.svh"
module spcr_core_tb;
    import spcr_pkg::*;
    localparam int FO_CYC = 4; // Shortened fail duty slot
    localparam int WK_CYC = 8; // Shortened wake filter
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic soft_reset = 1'h0;
    logic restart_mode = 1'h0;
    logic normal_mode = 1'h1;
    logic fail_active = 1'h1;
    logic [1:0] pin_wake_in = 2'h0;
    logic [11:0] hs_cfg = 12'h000;
    wire sck, csn, sdi, sdo, sdo_oe;
    logic p1, p2;
    logic [3:0] hs_drv, hs_ctl;
    logic [1:0] fdrv, ls_on, hs_on, wk_en, wk_lvl;
    int n_mismatch = 0;
    int checked = 0;
    int cnt = 0;
    int t0, tf, n;
    logic [6:0] a;
    logic [7:0] d;
    logic [6:0] regs [6] = '{7'h17, 7'h18, 7'h19, 7'h1C, 7'h1E, 7'h1D};

    always #10 clk = ~clk;
    always @(posedge clk) cnt <= cnt + 1;

    spcr_core #(.HS_NUM(4), .FO_STEP_CYC(FO_CYC),
        .WAKE_FILT_CYC(WK_CYC)) DUT (.clk(clk), .nrst(nrst),
        .spi_sck(sck), .spi_csn(csn), .spi_sdi(sdi), .spi_sdo(sdo),
        .spi_sdo_oe(sdo_oe), .soft_reset(soft_reset),
        .restart_mode(restart_mode), .normal_mode(normal_mode),
        .fail_active(fail_active), .pin_wake_in(pin_wake_in),
        .hs_cfg(hs_cfg), .pulse_one_out(p1), .pulse_two_out(p2),
        .hs_pwm_drive(hs_drv), .hs_pwm_ctl(hs_ctl),
        .pin_fail_drive(fdrv), .pin_low_side_on(ls_on),
        .pin_high_side_on(hs_on), .pin_wake_en(wk_en),
        .pin_wake_level(wk_lvl));

    spcr_host_model host (.clk(clk), .spi_sck(sck), .spi_csn(csn),
        .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe));

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_win(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [6:0] ad, input logic [7:0] dt);
        logic [7:0] r;
        host.xfer(ad, 1'h1, dt, r);
    endtask

    task automatic rd_chk(input logic [6:0] ad, input logic [7:0] e);
        logic [7:0] r;
        host.xfer(ad, 1'h0, 8'h00, r);
        chk_val(r, e);
    endtask

    // Bounded wait for a channel to go low; a hang ends the run
    task automatic wait_fall(input logic two, output int t);
        int k = 0;
        while ((two ? p2 : p1) !== 1'h0 && k < 20000) begin
            cyc(1);
            k++;
        end
        t = cnt;
        if (k >= 20000) begin
            n_mismatch++;
            test_done();
        end
    endtask

    // Readback: reserved frequency bits and unmapped places read zero
    function automatic logic [7:0] exp_rd(input logic [6:0] ad,
            input logic [7:0] dt);
        case (ad)
            7'h1C: exp_rd = dt & 8'h05;
            7'h17, 7'h18, 7'h19, 7'h1E: exp_rd = dt;
            default: exp_rd = 8'h00;
        endcase
    endfunction

    function automatic int fall_at(input int duty, input logic fast);
        fall_at = duty * (fast ? `SPCR_PWM400_STEP : `SPCR_PWM200_STEP);
    endfunction

    initial begin
        void'($urandom(93));
        cyc(10);
        nrst = 1'h1;
        t0 = cnt;
        cyc(3);
        // First period from reset: channel two fast, channel one slow
        wr(7'h1C, 8'hFC);
        wr(7'h19, 8'h08);
        wr(7'h18, 8'h06);
        chk_val({6'h00, p2, p1}, 8'h03);
        wait_fall(1'h1, tf);
        n = fall_at(8, 1);
        chk_win(tf - t0, n * 7 / 8, n * 9 / 8);
        wait_fall(1'h0, tf);
        n = fall_at(6, 0);
        chk_win(tf - t0, n * 7 / 8, n * 9 / 8);
        rd_chk(7'h1C, 8'h04);
        $display("test pwm_period done");
        rd_chk(7'h17, 8'h00);
        rd_chk(7'h1E, 8'h00);
        for (int i = 0; i < 12; i++) begin
            a = regs[i % 6];
            d = 8'($urandom);
            wr(a, d);
            rd_chk(a, exp_rd(a, d));
        end
        $display("test readback done");
        // Static extremes, routed to switches 0 and 1; no timer chosen
        hs_cfg = {3'h7, 3'h0, HS_BY_PULSE_TWO, HS_BY_PULSE_ONE};
        for (int s = 0; s < 2; s++) begin
            wr(7'h18, s ? 8'h00 : 8'hFF);
            wr(7'h19, s ? 8'hFF : 8'h00);
            for (int i = 0; i < 20; i++) begin
                cyc(50);
                chk_val({6'h00, p2, p1}, s ? 8'h02 : 8'h01);
                chk_val({hs_ctl, hs_drv}, s ? 8'h32 : 8'h31);
            end
        end
        $display("test extremes done");
        for (int c = 0; c < 8; c++) begin
            n = 7 - c;
            wr(7'h17, {2'h0, 3'(n), 3'(c)});
            cyc(3);
            chk_val({ls_on[0], hs_on[0], wk_en[0], fdrv[0]},
                {4'h0, c == 6, c == 7, c == 5, c < 4});
            chk_val({ls_on[1], hs_on[1], wk_en[1], n >= 4 && fdrv[1]},
                {4'h0, n == 6, n == 7, n == 5, 1'h0});
        end
        // Fail output duty: count high cycles over one whole period
        for (int f = 0; f < 4; f++) begin
            wr(7'h17, {2'(f), 6'h00});
            cyc(40 * FO_CYC);
            n = 0;
            repeat (40 * FO_CYC) begin
                cyc(1);
                n += (fdrv[1] === 1'h1);
            end
            chk_win(n, (8 >> f) * FO_CYC, (8 >> f) * FO_CYC);
        end
        // Both fail drives drop with the fail condition
        fail_active = 1'h0;
        cyc(3);
        chk_val({6'h00, fdrv}, 8'h00);
        fail_active = 1'h1;
        // Both pins as wake inputs: a short pulse is filtered out
        wr(7'h17, 8'h2D);
        pin_wake_in = 2'h3;
        cyc(WK_CYC / 2);
        pin_wake_in = 2'h0;
        cyc(WK_CYC * 3);
        chk_val({6'h00, wk_lvl}, 8'h00);
        pin_wake_in = 2'h3;
        cyc(WK_CYC + 6);
        chk_val({6'h00, wk_lvl}, 8'h03);
        $display("test pins done");
        wr(7'h1E, 8'hA5);
        wr(7'h18, 8'h33);
        wr(7'h1C, 8'h05);
        restart_mode = 1'h1;
        cyc(20);
        restart_mode = 1'h0;
        rd_chk(7'h18, 8'h33);
        rd_chk(7'h1C, 8'h05);
        rd_chk(7'h1E, 8'hA5);
        soft_reset = 1'h1;
        cyc(1);
        soft_reset = 1'h0;
        rd_chk(7'h18, 8'h00);
        rd_chk(7'h1C, 8'h00);
        rd_chk(7'h1E, 8'hA5);
        // Access outside normal mode is refused both ways
        normal_mode = 1'h0;
        wr(7'h1E, 8'h5A);
        rd_chk(7'h1E, 8'h00);
        normal_mode = 1'h1;
        rd_chk(7'h1E, 8'hA5);
        nrst = 1'h0;
        cyc(2);
        nrst = 1'h1;
        cyc(3);
        rd_chk(7'h1E, 8'h00);
        $display("test resets done");
        test_done();
    end
endmodule
